// File: design/standby_wakeup_defs.vh
/*
 * Constants for the standby wake-up controller: mode codes, edge codes,
 * warm-up select codes and counts.
 * Assumes it is included by bare name from files under design/.
 */
//
// Functional notes
// - Unmasked wake interrupt above mask level resumes in service routine, then next instruction.
// - Masked wake interrupt restarts at the standby instruction; request stays pending.
// - Nonmaskable wake interrupt is always serviced regardless of mask level.
// - Reset ends any standby; RAM kept, all other state initialized.
// - Interrupt wake-up keeps every internal state as before standby.
// - Idle wakes on all but DMA-complete outside doze; sleep on NMI, pins 0-4, RTC; stop on NMI, pins 0-4.
// - Stop wake starts warm-up; execution and clock output resume only after it.
// - DMA-complete wakes only from doze idle, ignored elsewhere.
// - Stop halts all activity including the oscillator.
// - Stop exit enters normal or slow per three return bits set beforehand.
// - Warm-up select 01 gives 2^8, 10 gives 2^14, 11 gives 2^16 cycles.
// - Warm-up applies even when the low-speed clock keeps running.
// - Stop pin drive bit 0 floats/disables pins, 1 keeps drive; ALE low, osc out high.
// - Pin wake enable routes pins 0-4 and RTC to wake with clock-generator polarity.
// - Pins 0-4 not wake-enabled are judged by the interrupt controller alone.
`ifndef STANDBY_WAKEUP_DEFS_VH
`define STANDBY_WAKEUP_DEFS_VH

// Standby request codes
`define MODE_IDLE 2'h1
`define MODE_SLEEP 2'h2
`define MODE_STOP 2'h3

// Wake edge field codes per source
`define EDGE_FALL 2'h2
`define EDGE_RISE 2'h3
`define EDGE_LOW 2'h0
`define EDGE_HIGH 2'h1

// Warm-up select codes and cycle counts
`define WUP_SEL_8 2'h1
`define WUP_SEL_14 2'h2
`define WUP_SEL_16 2'h3
`define WUP_CNT_8 17'h0_0100
`define WUP_CNT_14 17'h0_4000
`define WUP_CNT_16 17'h1_0000
`define WUP_CNT_W 17

`endif

// File: design/wake_edge_detect.v
/*
 * One wake pin edge/level detector with sticky request.
 * Assumes the pin input is already synchronised to clk_i.
 */
`timescale 1ns/1ns
`default_nettype none
module wake_edge_detect (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Pin and config
    input wire pin_i,
    input wire [1:0] edge_sel_i,
    input wire clear_i,
    // Result
    output reg hit_o
);
`include "standby_wakeup_defs.vh"

    reg last_reg;
    reg event_w;

    // Decode the chosen sensitivity
    always @* begin
        case (edge_sel_i)
            `EDGE_FALL: event_w = last_reg & ~pin_i;
            `EDGE_RISE: event_w = ~last_reg & pin_i;
            `EDGE_HIGH: event_w = pin_i;
            default: event_w = ~pin_i;
        endcase
    end

    // Sticky request; a new event beats a clear in the same cycle
    always @(posedge clk_i) begin
        if (rst_i) begin
            last_reg <= 1'b0;
            hit_o <= 1'b0;
        end else begin
            last_reg <= pin_i;
            if (event_w)
                hit_o <= 1'b1;
            else if (clear_i)
                hit_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: design/warmup_timer.v
/*
 * Oscillator warm-up counter.
 * Assumes start_i is a one-cycle pulse and the clock runs while counting.
 */
`timescale 1ns/1ns
`default_nettype none
module warmup_timer #(
    parameter CNT_W = 17
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire start_i,
    input wire [1:0] sel_i,
    // Status
    output reg busy_o,
    output reg done_o
);
`include "standby_wakeup_defs.vh"

    reg [CNT_W-1:0] count_reg;
    reg [CNT_W-1:0] limit_w;

    // Select count; unknown code falls back to the longest
    always @* begin
        case (sel_i)
            `WUP_SEL_8: limit_w = `WUP_CNT_8;
            `WUP_SEL_14: limit_w = `WUP_CNT_14;
            default: limit_w = `WUP_CNT_16;
        endcase
    end

    // Count from zero; done is a single-cycle pulse
    always @(posedge clk_i) begin
        if (rst_i) begin
            count_reg <= {CNT_W{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                count_reg <= {CNT_W{1'b0}};
                busy_o <= 1'b1;
            end else if (busy_o) begin
                if (count_reg == limit_w - 1'b1) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: design/standby_wakeup_control.v
/*
 * Standby exit controller: wake source qualification, resume decision,
 * warm-up timing, return clock mode and stop-time pin behaviour.
 * Assumes core and interrupt controller signals are on clk_i; wake pins
 * and NMI are asynchronous and are synchronised here.
 */
`timescale 1ns/1ns
`default_nettype none
module standby_wakeup_control #(
    parameter NPIN = 5,
    parameter NSRC = 8
) (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Core standby request
    input wire standby_req_i,
    input wire doze_i,
    input wire [1:0] standby_mode_i,
    input wire [2:0] core_mask_level_i,
    // Interrupt controller request
    input wire irq_pending_i,
    input wire [2:0] irq_level_i,
    input wire watchdog_irq_i,
    input wire dma_done_irq_i,
    input wire [NSRC-1:0] other_irq_i,
    // Asynchronous wake pins
    input wire nmi_pin_i,
    input wire [NPIN-1:0] ext_pin_i,
    input wire rtc_irq_i,
    // Clock generator wake config
    input wire [NPIN:0] pin_wake_enable_i,
    input wire [2*NPIN+1:0] cg_wake_edge_field_i,
    input wire [NPIN:0] cg_request_clear_i,
    input wire [1:0] warmup_select_i,
    input wire stop_pin_drive_bit_i,
    input wire return_fast_osc_enable_i,
    input wire return_slow_osc_enable_i,
    input wire return_sysclk_select_i,
    // Core resume controls
    output reg core_run_o,
    output reg resume_isr_o,
    output reg resume_restart_o,
    output reg nmi_service_o,
    // Clocking and pins
    output reg osc_enable_o,
    output reg sysclk_out_enable_o,
    output reg slow_mode_o,
    output reg fast_osc_on_o,
    output reg slow_osc_on_o,
    output reg pin_out_enable_o,
    output reg pin_in_enable_o,
    output reg ale_force_low_o,
    output reg osc_out_force_high_o,
    output reg [1:0] state_o,
    output reg [NPIN:0] cg_wake_pending_o
);
`include "standby_wakeup_defs.vh"

    // =====================================================================
    // States
    localparam [2:0] ST_RUN = 3'h0;
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_SLEEP = 3'h2;
    localparam [2:0] ST_STOP = 3'h3;
    localparam [2:0] ST_WARM = 3'h4;

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg doze_reg;
    reg stop_exit_reg;

    // =====================================================================
    // Synchronisers for asynchronous pins
    reg [NPIN+1:0] sync1_reg;
    reg [NPIN+1:0] sync2_reg;
    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= {(NPIN+2){1'b0}};
            sync2_reg <= {(NPIN+2){1'b0}};
        end else begin
            sync1_reg <= {nmi_pin_i, rtc_irq_i, ext_pin_i};
            sync2_reg <= sync1_reg;
        end
    end

    wire nmi_s = sync2_reg[NPIN+1];
    wire [NPIN:0] cg_pin_s = sync2_reg[NPIN:0];

    // =====================================================================
    // Clock-generator wake detectors, one per pin plus RTC
    wire [NPIN:0] cg_hit;
    genvar gi;
    generate
        for (gi = 0; gi <= NPIN; gi = gi + 1) begin : g_det
            wake_edge_detect u_det (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(cg_pin_s[gi]),
                .edge_sel_i(cg_wake_edge_field_i[2*gi+1:2*gi]),
                .clear_i(cg_request_clear_i[gi]),
                .hit_o(cg_hit[gi])
            );
        end
    endgenerate

    // Only enabled pins count; disabled ones are left to the controller
    wire [NPIN:0] cg_wake = cg_hit & pin_wake_enable_i;
    wire pin_wake = |cg_wake[NPIN-1:0];
    wire rtc_wake = cg_wake[NPIN];

    // NMI falling edge, seen only after the second flip-flop
    reg nmi_last_reg;
    wire nmi_event = nmi_last_reg & ~nmi_s;

    // =====================================================================
    // Wake qualification per standby state
    reg wake_w;
    always @* begin
        case (state_reg)
            ST_IDLE: wake_w = nmi_event | irq_pending_i | watchdog_irq_i | pin_wake
                | rtc_wake | (|other_irq_i) | (dma_done_irq_i & doze_reg);
            ST_SLEEP: wake_w = nmi_event | pin_wake | rtc_wake;
            ST_STOP: wake_w = nmi_event | pin_wake;
            default: wake_w = 1'b0;
        endcase
    end

    // Resume decision for the interrupt that woke the core
    wire unmasked = irq_pending_i & (irq_level_i > core_mask_level_i);

    // =====================================================================
    // Warm-up timer
    wire warm_start = wake_w & ((state_reg == ST_STOP) | (state_reg == ST_SLEEP));
    wire warm_busy;
    wire warm_done;
    warmup_timer #(
        .CNT_W(`WUP_CNT_W)
    ) u_warm (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(warm_start),
        .sel_i(warmup_select_i),
        .busy_o(warm_busy),
        .done_o(warm_done)
    );

    // =====================================================================
    // Next state
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (standby_req_i) begin
                    if (doze_i)
                        state_next = ST_IDLE;
                    else if (standby_mode_i == `MODE_SLEEP)
                        state_next = ST_SLEEP;
                    else if (standby_mode_i == `MODE_STOP)
                        state_next = ST_STOP;
                    else
                        state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (wake_w)
                    state_next = ST_RUN;
            end
            ST_SLEEP, ST_STOP: begin
                if (warm_start)
                    state_next = ST_WARM;
            end
            ST_WARM: begin
                if (warm_done)
                    state_next = ST_RUN;
            end
            default: state_next = ST_RUN;
        endcase
    end

    // Wake cause latched on entry to warm-up so the decision uses it later
    reg nmi_cause_reg;
    wire leaving = (state_reg != ST_RUN) & (state_next == ST_RUN);

    // =====================================================================
    // State and outputs; reset initializes everything here, RAM is outside
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ST_RUN;
            doze_reg <= 1'b0;
            stop_exit_reg <= 1'b0;
            nmi_last_reg <= 1'b0;
            nmi_cause_reg <= 1'b0;
            core_run_o <= 1'b1;
            resume_isr_o <= 1'b0;
            resume_restart_o <= 1'b0;
            nmi_service_o <= 1'b0;
            osc_enable_o <= 1'b1;
            sysclk_out_enable_o <= 1'b1;
            slow_mode_o <= 1'b0;
            fast_osc_on_o <= 1'b1;
            slow_osc_on_o <= 1'b1;
            pin_out_enable_o <= 1'b1;
            pin_in_enable_o <= 1'b1;
            ale_force_low_o <= 1'b0;
            osc_out_force_high_o <= 1'b0;
            state_o <= 2'h0;
            cg_wake_pending_o <= {(NPIN+1){1'b0}};
        end else begin
            state_reg <= state_next;
            nmi_last_reg <= nmi_s;
            cg_wake_pending_o <= cg_hit;
            resume_isr_o <= 1'b0;
            resume_restart_o <= 1'b0;
            nmi_service_o <= 1'b0;
            if (state_reg == ST_RUN && state_next != ST_RUN) begin
                doze_reg <= doze_i;
                stop_exit_reg <= (state_next == ST_STOP);
                nmi_cause_reg <= 1'b0;
            end
            if (wake_w && nmi_event)
                nmi_cause_reg <= 1'b1;
            // Resume decision; core state itself is untouched by wake-up
            if (leaving) begin
                if (nmi_event | nmi_cause_reg)
                    nmi_service_o <= 1'b1;
                else if (unmasked)
                    resume_isr_o <= 1'b1;
                else
                    resume_restart_o <= 1'b1;
                // Return clock mode applies only after stop
                if (stop_exit_reg) begin
                    slow_mode_o <= return_sysclk_select_i;
                    fast_osc_on_o <= return_fast_osc_enable_i;
                    slow_osc_on_o <= return_slow_osc_enable_i;
                end
            end
            // Core and clock output run only outside standby and warm-up
            core_run_o <= (state_next == ST_RUN);
            sysclk_out_enable_o <= (state_next == ST_RUN);
            // Oscillator off in stop only; restarts for warm-up
            osc_enable_o <= (state_next != ST_STOP);
            // Stopped pin behaviour
            if (state_next == ST_STOP) begin
                pin_out_enable_o <= stop_pin_drive_bit_i;
                pin_in_enable_o <= stop_pin_drive_bit_i;
                ale_force_low_o <= 1'b1;
                osc_out_force_high_o <= 1'b1;
            end else begin
                pin_out_enable_o <= 1'b1;
                pin_in_enable_o <= 1'b1;
                ale_force_low_o <= 1'b0;
                osc_out_force_high_o <= 1'b0;
            end
            state_o <= (state_next == ST_WARM) ? `MODE_STOP : state_next[1:0];
        end
    end

    // Warm-up busy is visible for debug through state; keep it read
    wire unused_ok = warm_busy;
endmodule
`default_nettype wire

// File: testbench/standby_wakeup_assertions.sv
/*
 * Port checker for the standby wake-up controller.
 * Assumes one clock domain with a synchronous active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none
module standby_wakeup_assertions (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Configuration
    input wire logic stop_pin_drive_bit_i,
    // Core and clock outputs
    input wire logic core_run_o,
    input wire logic resume_isr_o,
    input wire logic resume_restart_o,
    input wire logic nmi_service_o,
    input wire logic osc_enable_o,
    input wire logic sysclk_out_enable_o,
    // Pin outputs
    input wire logic pin_out_enable_o,
    input wire logic pin_in_enable_o,
    input wire logic ale_force_low_o,
    input wire logic osc_out_force_high_o,
    input wire logic [1:0] state_o
);
    // ==========================================
    // Properties
    // Single domain, so one clock and one disable serve all
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_reset_run: assert property ($fell(rst_i) |-> core_run_o && state_o == 2'h0)
        else $error("reset release not in run");
    chk_core_frozen: assert property (state_o != 2'h0 |-> !core_run_o)
        else $error("core runs in standby");
    // A reset also raises core_run_o without any wake-up
    chk_wake_cause: assert property ($rose(core_run_o) && !$past(rst_i) |->
        resume_isr_o || resume_restart_o || nmi_service_o)
        else $error("resume without a resume kind");
    chk_isr_pulse: assert property (resume_isr_o |=> !resume_isr_o)
        else $error("service resume longer than one cycle");
    chk_isr_restart: assert property (!(resume_isr_o && resume_restart_o))
        else $error("service and restart together");
    chk_nmi_served: assert property (nmi_service_o |-> !resume_restart_o)
        else $error("nonmaskable wake restarted");
    // Warm-up after sleep also shows code 3, with the oscillator already running
    chk_stop_osc: assert property ($rose(state_o == 2'h3) && $past(state_o) == 2'h0 |->
        !osc_enable_o)
        else $error("oscillator kept in stop");
    chk_stop_sysclk: assert property (state_o == 2'h3 |-> !sysclk_out_enable_o)
        else $error("clock output before warm-up end");
    // Pins follow the drive bit only while fully stopped
    chk_stop_pins: assert property (state_o == 2'h3 && !osc_enable_o |->
        ale_force_low_o && osc_out_force_high_o && pin_out_enable_o == stop_pin_drive_bit_i
        && pin_in_enable_o == stop_pin_drive_bit_i)
        else $error("stop pin state wrong");
endmodule
bind standby_wakeup_control standby_wakeup_assertions chk (.clk_i, .rst_i,
    .stop_pin_drive_bit_i, .core_run_o, .resume_isr_o, .resume_restart_o, .nmi_service_o,
    .osc_enable_o, .sysclk_out_enable_o, .pin_out_enable_o, .pin_in_enable_o,
    .ale_force_low_o, .osc_out_force_high_o, .state_o);
`default_nettype wire

// File: testbench/core_interrupt_controller_model.sv
/*
 * Behavioural core and interrupt controller facing the wake-up controller.
 * Assumes bench commands change at the falling edge.
 */
`timescale 1ns/1ns
`default_nettype none
module core_interrupt_controller_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Bench commands
    input wire logic enter_i,
    input wire logic raise_i,
    input wire logic [2:0] level_i,
    // Controller feedback
    input wire logic [1:0] state_i,
    input wire logic resume_isr_i,
    // Toward the controller
    output logic standby_req_o,
    output logic irq_pending_o,
    output logic [2:0] irq_level_o
);
    logic req_reg = 1'b0;
    logic pend_reg = 1'b0;
    logic [2:0] level_reg = 3'h0;
    assign standby_req_o = req_reg;
    assign irq_pending_o = pend_reg;
    assign irq_level_o = level_reg;

    // Standby request held until the controller has left run
    always @(posedge clk_i) begin
        if (rst_i) begin
            req_reg <= 1'b0;
        end else if (enter_i) begin
            req_reg <= 1'b1;
        end else if (state_i != 2'h0) begin
            req_reg <= 1'b0;
        end
    end

    // Request kept until service begins; a released level shows garbage
    always @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0;
        end else if (raise_i) begin
            pend_reg <= 1'b1;
            level_reg <= level_i;
        end else if (resume_isr_i && pend_reg) begin
            pend_reg <= 1'b0;
            level_reg <= ~level_reg;
        end
    end
endmodule
`default_nettype wire

// File: testbench/testbench.sv
/*
 * Self-checking bench for the standby wake-up controller.
 * Assumes the design header sits on the include path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "standby_wakeup_defs.vh"
module testbench;
    typedef struct packed {
        logic [1:0] mode;
        logic doze;
        logic [2:0] src;
        logic [2:0] mask;
        logic [2:0] lvl;
        logic [1:0] sel;
        logic [2:0] want;
    } row_t;
    // Sources: 0 ctrl,1 watchdog,2 dma,3 pin0,4 rtc,5 nmi,6 other
    // Wants: 0 none,1 service,2 restart,3 nmi,4 any wake
    row_t rows [16] = '{
        '{2'h1, 1'h0, 3'h0, 3'h3, 3'h5, 2'h1, 3'h1}, '{2'h1, 1'h0, 3'h0, 3'h3, 3'h3, 2'h1, 3'h2},
        '{2'h1, 1'h0, 3'h6, 3'h1, 3'h2, 2'h1, 3'h1}, '{2'h1, 1'h0, 3'h1, 3'h0, 3'h0, 2'h1, 3'h4},
        '{2'h1, 1'h1, 3'h2, 3'h0, 3'h0, 2'h1, 3'h4}, '{2'h1, 1'h0, 3'h2, 3'h0, 3'h0, 2'h1, 3'h0},
        '{2'h2, 1'h0, 3'h1, 3'h0, 3'h0, 2'h1, 3'h0}, '{2'h2, 1'h0, 3'h2, 3'h0, 3'h0, 2'h1, 3'h0},
        '{2'h2, 1'h0, 3'h0, 3'h0, 3'h5, 2'h1, 3'h0}, '{2'h2, 1'h0, 3'h4, 3'h2, 3'h6, 2'h1, 3'h1},
        '{2'h2, 1'h0, 3'h3, 3'h4, 3'h1, 2'h1, 3'h2}, '{2'h3, 1'h0, 3'h4, 3'h0, 3'h6, 2'h1, 3'h0},
        '{2'h3, 1'h0, 3'h3, 3'h0, 3'h7, 2'h1, 3'h1}, '{2'h3, 1'h0, 3'h5, 3'h7, 3'h0, 2'h2, 3'h3},
        '{2'h3, 1'h0, 3'h3, 3'h7, 3'h7, 2'h2, 3'h2}, '{2'h1, 1'h0, 3'h5, 3'h7, 3'h0, 2'h1, 3'h3}};
    row_t stop_row = '{2'h3, 1'h0, 3'h3, 3'h0, 3'h1, 2'h1, 3'h1};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic standby_req_i, doze_i, irq_pending_i, watchdog_irq_i, dma_done_irq_i, nmi_pin_i;
    logic rtc_irq_i, stop_pin_drive_bit_i, return_fast_osc_enable_i, return_slow_osc_enable_i;
    logic return_sysclk_select_i, cmd_enter, cmd_raise;
    logic [1:0] standby_mode_i, warmup_select_i, state_o;
    logic [2:0] core_mask_level_i, irq_level_i, cmd_level;
    logic [7:0] other_irq_i;
    logic [4:0] ext_pin_i;
    logic [5:0] pin_wake_enable_i, cg_request_clear_i, cg_wake_pending_o;
    logic [11:0] cg_wake_edge_field_i;
    logic core_run_o, resume_isr_o, resume_restart_o, nmi_service_o, osc_enable_o;
    logic sysclk_out_enable_o, slow_mode_o, fast_osc_on_o, slow_osc_on_o, pin_out_enable_o;
    logic pin_in_enable_o, ale_force_low_o, osc_out_force_high_o;
    int err_total = 0;
    int tests_run = 0;
    int n, w;

    // ==========================================
    // Design, partner and clock
    standby_wakeup_control dut (.*);
    core_interrupt_controller_model partner (.clk_i, .rst_i, .enter_i(cmd_enter), .raise_i(cmd_raise),
        .level_i(cmd_level), .state_i(state_o), .resume_isr_i(resume_isr_o),
        .standby_req_o(standby_req_i), .irq_pending_o(irq_pending_i), .irq_level_o(irq_level_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // ==========================================
    // Tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Quiet sources and default wake setup; callers sit at a falling edge
    task automatic do_reset(input int cycles);
        rst_i = 1'b1;
        {cmd_enter, cmd_raise, cmd_level, watchdog_irq_i, dma_done_irq_i} = '0;
        {rtc_irq_i, ext_pin_i, other_irq_i, cg_request_clear_i} = '0;
        nmi_pin_i = 1'b1;
        return_slow_osc_enable_i = 1'b1;
        pin_wake_enable_i = 6'h3F;
        cg_wake_edge_field_i = 12'hFFF;
        repeat (cycles) @(negedge clk_i);
        rst_i = 1'b0;
    endtask
    // Return bits and warm-up set before the request, as software must
    task automatic enter(input row_t r);
        @(negedge clk_i);
        {standby_mode_i, doze_i, core_mask_level_i, warmup_select_i} = {r.mode, r.doze, r.mask, r.sel};
        stop_pin_drive_bit_i = r.mask[0];
        return_fast_osc_enable_i = ~r.mask[0];
        return_sysclk_select_i = r.mask[0];
        return_slow_osc_enable_i = ~r.mask[1];
        @(negedge clk_i);
        cmd_enter = 1'b1;
        @(negedge clk_i);
        cmd_enter = 1'b0;
        repeat (8) if (state_o === 2'h0) @(negedge clk_i);
    endtask
    // Controller request leads the raw lines, so its level is known when they wake
    task automatic apply(input logic [2:0] src, input logic [2:0] lvl);
        @(negedge clk_i);
        cmd_level = lvl;
        cmd_raise = src inside {3'h0, 3'h3, 3'h4, 3'h6};
        @(negedge clk_i);
        cmd_raise = 1'b0;
        {watchdog_irq_i, dma_done_irq_i, ext_pin_i[0]} = {src == 3'h1, src == 3'h2, src == 3'h3};
        {rtc_irq_i, nmi_pin_i, other_irq_i[3]} = {src == 3'h4, src != 3'h5, src == 3'h6};
    endtask
    // Counts cycles to wake and cycles spent warming up after stop or sleep
    task automatic wait_wake(input int lim, output int cnt, output int warm);
        cnt = 0;
        warm = 0;
        while (core_run_o !== 1'b1 && cnt < lim) begin
            @(negedge clk_i);
            cnt++;
            if (state_o === 2'h3 && osc_enable_o === 1'b1) warm++;
        end
    endtask
    function automatic int warm_len(input logic [1:0] sel);
        return sel == 2'h1 ? `WUP_CNT_8 : sel == 2'h2 ? `WUP_CNT_14 : `WUP_CNT_16;
    endfunction
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================
    // Watchdog: the 50000-cycle reset hold and the warm-ups plus margin
    initial begin
        repeat (95000) @(posedge clk_i);
        err_total++;
        complete_run();
    end

    // ==========================================
    // Main sequence
    initial begin
        do_reset(12);
        foreach (rows[i]) begin
            do_reset(2);
            enter(rows[i]);
            check("standby state", rows[i].doze ? 2'h1 : rows[i].mode, state_o);
            apply(rows[i].src, rows[i].lvl);
            wait_wake(rows[i].want == 3'h0 ? 300 : 70000, n, w);
            check("woken", rows[i].want != 3'h0, core_run_o);
            if (rows[i].want == 3'h1) check("service resume", 1, resume_isr_o);
            if (rows[i].want == 3'h2) check("restart resume", 1, resume_restart_o);
            if (rows[i].want == 3'h3) check("nmi service", 1, nmi_service_o);
            if (rows[i].want == 3'h2 && rows[i].src == 3'h3) check("held", 1, cg_wake_pending_o[0]);
            if (rows[i].want != 3'h0 && rows[i].mode == 2'h2) check("sleep warm", 1, n > warm_len(rows[i].sel));
            if (rows[i].want != 3'h0 && rows[i].mode == 2'h3) begin
                check("warm cycles", warm_len(rows[i].sel) + 1, w);
                check("clock out", 1, sysclk_out_enable_o);
                check("fast osc", return_fast_osc_enable_i, fast_osc_on_o);
                check("slow mode", return_sysclk_select_i, slow_mode_o);
                check("slow osc", return_slow_osc_enable_i, slow_osc_on_o);
            end
        end
        // Reset in mid warm-up returns straight to run
        do_reset(2);
        enter(stop_row);
        apply(3'h3, 3'h1);
        repeat (20) @(negedge clk_i);
        // Reset ending the warm-up is held 500 us, as a flash part needs
        do_reset(50000);
        check("run after reset", 1, core_run_o);
        check("state after reset", 0, state_o);
        check("osc after reset", 1, osc_enable_o);
        // Pin not enabled for wake leaves stop untouched
        do_reset(2);
        pin_wake_enable_i = 6'h3E;
        enter(stop_row);
        apply(3'h3, 3'h1);
        wait_wake(300, n, w);
        check("unenabled pin", 0, core_run_o);
        // Falling-edge pin set up in the required order
        do_reset(2);
        pin_wake_enable_i = 6'h3E;
        ext_pin_i[0] = 1'b1;
        cg_wake_edge_field_i[1:0] = 2'h2;
        cg_request_clear_i = 6'h01;
        @(negedge clk_i);
        cg_request_clear_i = 6'h00;
        pin_wake_enable_i = 6'h3F;
        enter(stop_row);
        ext_pin_i[0] = 1'b0;
        wait_wake(2000, n, w);
        check("falling pin wake", 1, core_run_o);
        complete_run();
    end
endmodule
`default_nettype wire
